//--- ccsw_pkg.sv
//==============================================================
// Constants of the dual oscillator clock switch
//==============================================================
package ccsw_pkg;

	// Register bus shape
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 4;

	// Register offsets
	localparam logic [15:0] CLK_CTRL_ADDR = 16'hFF00;
	localparam logic [15:0] PRESCALE_ADDR = 16'hFF02;

	// Field positions in the clock control register
	localparam int          CPU_SEL_BIT   = 3;
	localparam int          FAST_EN_BIT   = 2;
	localparam int          CORE_V_BIT    = 0;

	// Reset values
	localparam logic [1:0]  PRESCALE_RST  = 2'h3;
	localparam logic        CTRL_BIT_RST  = 1'h0;

	// Clock rate and source frequencies in Hz
	localparam int          CLK_HZ        = 250000000;
	localparam int          XTAL_LO_HZ    = 32768;
	localparam int          XTAL_MID_HZ   = 76800;
	localparam int          XTAL_HI_HZ    = 153600;
	localparam int          FAST_RC_HZ    = 400000;

	// Longest period allowed: rounds down
	localparam int          FAST_DIV      = CLK_HZ / FAST_RC_HZ;
	localparam int          SLOW_DIV      = CLK_HZ / XTAL_LO_HZ;

	// Normalised peripheral tick in Hz and prescaler ratios
	localparam int          PERIPH_HZ     = 256;
	localparam logic [9:0]  PRE_DIV_LO    = 10'(XTAL_LO_HZ / PERIPH_HZ);
	localparam logic [9:0]  PRE_DIV_MID   = 10'(XTAL_MID_HZ / PERIPH_HZ);
	localparam logic [9:0]  PRE_DIV_HI    = 10'(XTAL_HI_HZ / PERIPH_HZ);

	// Source clocks per CPU instruction cycle
	localparam int          SRC_PER_CYCLE = 2;

	// Changeover sequencer states
	typedef enum logic [0:0] {
		CCSW_RUN,
		CCSW_WAIT_NEW
	} ccsw_state_t;

endpackage : ccsw_pkg

//--- ccsw_divider.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Enable-pulse divider: one pulse every i_limit enabled cycles
//==============================================================
module ccsw_divider #(
	parameter int WIDTH = 13
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_enable,
	input  wire logic [WIDTH-1:0] i_limit,
	output logic                  o_tick
);

	logic [WIDTH-1:0] count_reg;   // Enabled cycles counted so far
	logic [WIDTH-1:0] count_next;  // Next count
	logic             wrap;        // Last cycle of a period

	assign wrap       = i_enable && (count_reg >= i_limit - WIDTH'(1));
	assign count_next = wrap ? '0 : count_reg + WIDTH'(1);

	//==========================================================
	// Counter; holds between enables so a strobe can step it
	//==========================================================
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			count_reg <= '0;
		else if (i_enable)
			count_reg <= count_next;
	end

	//==========================================================
	// Registered output pulse
	//==========================================================
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			o_tick <= 1'b0;
		else
			o_tick <= wrap;
	end

endmodule : ccsw_divider
`default_nettype wire

//--- ccsw_clock_switch.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Dual oscillator clock switch
//==============================================================
// Contract
// - Slow crystal clocks CPU by default
// - Software selects fast or slow CPU clock
// - Prescaler normalises three crystal frequencies
// - Fast source up to 400 kHz, feeds peripherals
// - Fast oscillator enable starts, stops fast source
// - Core select: one 1.45 V, zero 1.2 V
// - Instruction cycle is two source clocks
// - Fast select ignored at low core voltage
// - Prescaler codes 1x, 01, 00; reset 11
module ccsw_clock_switch
	import ccsw_pkg::*;
#(
	parameter int SLOW_DIV_P = SLOW_DIV,
	parameter int FAST_DIV_P = FAST_DIV
) (
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_write,
	input  wire logic              i_read,
	output logic      [DATA_W-1:0] o_rdata,
	output logic                   o_slow_tick,
	output logic                   o_fast_tick,
	output logic                   o_fast_osc_running,
	output logic                   o_core_voltage_high,
	output logic                   o_cpu_src_tick,
	output logic                   o_cpu_cycle_tick,
	output logic                   o_cpu_on_fast,
	output logic                   o_periph_tick
);

	//==========================================================
	// Declarations
	//==========================================================
	logic        cpu_clock_select_reg;  // Stored fast select request
	logic        fast_osc_enable_reg;   // Fast oscillator run
	logic        core_voltage_sel_reg;  // High core voltage
	logic [1:0]  prescaler_sel_reg;     // Prescaler code
	logic [3:0]  rdata_next;            // Read mux
	logic        wr_ctrl;               // Write to control register
	logic        wr_pre;                // Write to prescaler register
	logic        sel_next;              // Filtered select on write
	logic        slow_tick;             // Slow crystal source edge
	logic        fast_tick;             // Fast RC source edge
	logic        fast_clear;            // Restarts fast source while off
	logic [9:0]  pre_limit;             // Prescaler ratio
	logic        on_fast_reg;           // Source now driving the CPU
	logic        phase_reg;             // Half of instruction cycle
	ccsw_state_t state_reg;             // Changeover state
	ccsw_state_t state_next;            // Next changeover state
	logic        want_fast;             // Source requested
	logic        old_tick;              // Edge of current source
	logic        new_tick;              // Edge of requested source
	logic        cycle_end;             // Last edge of a full cycle
	logic        run_cpu;               // CPU ticks allowed

	// Prescaler decode
	function automatic logic [9:0] pre_ratio(input logic [1:0] code);
		if (code[1])
			pre_ratio = PRE_DIV_HI;
		else if (code[0])
			pre_ratio = PRE_DIV_MID;
		else
			pre_ratio = PRE_DIV_LO;
	endfunction : pre_ratio

	//==========================================================
	// Register decode
	//==========================================================
	assign wr_ctrl  = i_write && (i_addr == CLK_CTRL_ADDR);
	assign wr_pre   = i_write && (i_addr == PRESCALE_ADDR);
	assign sel_next = i_wdata[CPU_SEL_BIT] && core_voltage_sel_reg;

	// Read mux; unmapped and reserved bits read as zero
	assign rdata_next =
		(i_addr == CLK_CTRL_ADDR) ?
			{cpu_clock_select_reg, fast_osc_enable_reg, 1'b0,
			 core_voltage_sel_reg} :
		(i_addr == PRESCALE_ADDR) ? {2'b00, prescaler_sel_reg} :
		4'h0;

	//==========================================================
	// Control register
	//==========================================================
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			cpu_clock_select_reg <= CTRL_BIT_RST;
			fast_osc_enable_reg  <= CTRL_BIT_RST;
			core_voltage_sel_reg <= CTRL_BIT_RST;
		end
		else if (wr_ctrl)
		begin
			cpu_clock_select_reg <= sel_next;
			fast_osc_enable_reg  <= i_wdata[FAST_EN_BIT];
			core_voltage_sel_reg <= i_wdata[CORE_V_BIT];
		end
	end

	//==========================================================
	// Prescaler register and read data
	//==========================================================
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			prescaler_sel_reg <= PRESCALE_RST;
			o_rdata           <= 4'h0;
		end
		else
		begin
			if (wr_pre)
				prescaler_sel_reg <= i_wdata[1:0];
			o_rdata <= i_read ? rdata_next : 4'h0;
		end
	end

	//==========================================================
	// Oscillator models and prescaler
	//==========================================================
	ccsw_divider #(.WIDTH(14)) u_slow (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_enable (1'b1),
		.i_limit  (14'(SLOW_DIV_P)),
		.o_tick   (slow_tick)
	);

	// Cleared while off, so restart is a full period
	assign fast_clear = i_reset || !fast_osc_enable_reg;

	ccsw_divider #(.WIDTH(10)) u_fast (
		.i_clk    (i_clk),
		.i_reset  (fast_clear),
		.i_enable (fast_osc_enable_reg),
		.i_limit  (10'(FAST_DIV_P)),
		.o_tick   (fast_tick)
	);

	assign pre_limit = pre_ratio(prescaler_sel_reg);
	ccsw_divider #(.WIDTH(10)) u_pre (
		.i_clk    (i_clk),
		.i_reset  (i_reset),
		.i_enable (slow_tick),
		.i_limit  (pre_limit),
		.o_tick   (o_periph_tick)
	);

	assign o_slow_tick         = slow_tick;
	// Fast clock to timer and frequency output
	assign o_fast_tick         = fast_tick;
	assign o_fast_osc_running  = fast_osc_enable_reg;
	assign o_core_voltage_high = core_voltage_sel_reg;

	//==========================================================
	// Changeover sequencer
	//==========================================================
	// Low voltage keeps slow source
	assign want_fast = cpu_clock_select_reg && core_voltage_sel_reg;
	assign old_tick  = on_fast_reg ? fast_tick : slow_tick;
	assign new_tick  = want_fast ? fast_tick : slow_tick;
	assign cycle_end = old_tick && phase_reg;
	assign run_cpu   = (state_reg == CCSW_RUN);

	// Next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			CCSW_RUN:
				// Leave only after a whole cycle
				if ((want_fast != on_fast_reg) && cycle_end)
					state_next = CCSW_WAIT_NEW;
			CCSW_WAIT_NEW:
				// Resume on first edge of new source
				if (new_tick)
					state_next = CCSW_RUN;
			default:
				state_next = CCSW_RUN;
		endcase
	end

	// State and source registers
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			state_reg   <= CCSW_RUN;
			on_fast_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			// Take the new source at a safe edge
			if (state_reg == CCSW_WAIT_NEW && new_tick)
				on_fast_reg <= want_fast;
		end
	end

	//==========================================================
	// Instruction cycle phase
	//==========================================================
	always_ff @(posedge i_clk)
	begin
		if (i_reset || !run_cpu)
			phase_reg <= 1'b0;
		else if (old_tick)
			phase_reg <= ~phase_reg;
	end

	assign o_cpu_src_tick   = run_cpu && old_tick;
	assign o_cpu_cycle_tick = run_cpu && cycle_end;
	assign o_cpu_on_fast    = on_fast_reg;

endmodule : ccsw_clock_switch
`default_nettype wire

//--- ccsw_checker.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Port checker of the clock switch
//==============================================================
module ccsw_checker
	import ccsw_pkg::*;
#(
	parameter int SLOW_DIV_P = SLOW_DIV,
	parameter int FAST_DIV_P = FAST_DIV
) (
	input wire logic              i_clk,
	input wire logic              i_reset,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_write,
	input wire logic              i_read,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic              o_slow_tick,
	input wire logic              o_fast_tick,
	input wire logic              o_fast_osc_running,
	input wire logic              o_core_voltage_high,
	input wire logic              o_cpu_src_tick,
	input wire logic              o_cpu_cycle_tick,
	input wire logic              o_cpu_on_fast,
	input wire logic              o_periph_tick
);
	int   gap_reg;  // Cycles since the last slow edge
	logic seen_reg; // A slow edge came since reset

	// Counts the spacing of slow edges
	always_ff @(posedge i_clk)
	begin
		gap_reg  <= (i_reset || o_slow_tick) ? 0 : gap_reg + 1;
		seen_reg <= !i_reset && (seen_reg || o_slow_tick);
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// Write to the control register
	sequence s_ctrl_wr;
		i_write && i_addr == CLK_CTRL_ADDR;
	endsequence
	// Read of the prescaler register
	sequence s_pre_rd;
		i_read && i_addr == PRESCALE_ADDR;
	endsequence

	property p_rst;
		$past(i_reset) |-> !o_cpu_on_fast && !o_core_voltage_high;
	endproperty
	property p_rd_idle;
		!i_read |=> o_rdata == 4'h0;
	endproperty
	property p_pre_rd;
		s_pre_rd |=> o_rdata[3:2] == 2'h0;
	endproperty
	property p_core;
		s_ctrl_wr |=> o_core_voltage_high == $past(i_wdata[CORE_V_BIT]);
	endproperty
	property p_fast_en;
		s_ctrl_wr |=> o_fast_osc_running == $past(i_wdata[FAST_EN_BIT]);
	endproperty
	property p_fast_off;
		!o_fast_osc_running [*3] |-> !o_fast_tick;
	endproperty
	property p_go_fast;
		$rose(o_cpu_on_fast) |-> o_core_voltage_high && o_fast_osc_running;
	endproperty
	property p_src_sel;
		o_cpu_src_tick |-> (o_cpu_on_fast ? o_fast_tick : o_slow_tick);
	endproperty
	property p_no_runt;
		$changed(o_cpu_on_fast) |-> !o_cpu_src_tick;
	endproperty
	property p_slow_gap;
		o_slow_tick && seen_reg |-> gap_reg == SLOW_DIV_P - 1;
	endproperty

	a_rst: assert property (p_rst) else $error("not slow after reset");
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	a_pre_rd: assert property (p_pre_rd) else $error("prescaler top bits");
	a_core: assert property (p_core) else $error("core select wrong");
	a_fast_en: assert property (p_fast_en) else $error("fast enable wrong");
	a_fast_off: assert property (p_fast_off) else $error("fast edge when off");
	a_go_fast: assert property (p_go_fast) else $error("fast too early");
	a_src_sel: assert property (p_src_sel) else $error("cpu edge source");
	a_slow_gap: assert property (p_slow_gap) else $error("slow period");
	a_no_runt: assert property (p_no_runt) else $error("runt cpu edge");
endmodule : ccsw_checker
`default_nettype wire

//--- ccsw_clock_switch_tb.sv
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// Testbench of the clock switch
//==============================================================
module ccsw_clock_switch_tb
	import ccsw_pkg::*;
;
	localparam int SP = 20; // Short slow period
	localparam int FP = 4;  // Short fast period
	logic              i_clk = 1'b0, i_reset = 1'b1;
	logic              i_write = 1'b0, i_read = 1'b0;
	logic [ADDR_W-1:0] i_addr = 16'h0000;
	logic [DATA_W-1:0] i_wdata = 4'h0, o_rdata;
	logic              o_slow_tick, o_fast_tick, o_fast_osc_running;
	logic              o_core_voltage_high, o_cpu_src_tick;
	logic              o_cpu_cycle_tick, o_cpu_on_fast, o_periph_tick;
	int                miscompares = 0, comparisons = 0, n;

	ccsw_clock_switch #(.SLOW_DIV_P(SP), .FAST_DIV_P(FP)) ccsw_clock_switch_i (
		.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
		.o_rdata(o_rdata), .o_slow_tick(o_slow_tick),
		.o_fast_tick(o_fast_tick), .o_fast_osc_running(o_fast_osc_running),
		.o_core_voltage_high(o_core_voltage_high),
		.o_cpu_src_tick(o_cpu_src_tick), .o_cpu_cycle_tick(o_cpu_cycle_tick),
		.o_cpu_on_fast(o_cpu_on_fast), .o_periph_tick(o_periph_tick));

	// Clock of 4 ns
	always #2 i_clk = ~i_clk;

	// Compares and counts
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// One-cycle register write
	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		@(posedge i_clk);
		{i_write, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		i_write <= 1'b0;
	endtask : wr

	// One-cycle read, data taken in the following cycle
	task automatic rd(input logic [15:0] a, input logic [3:0] exp);
		@(posedge i_clk);
		{i_read, i_addr} <= {1'b1, a};
		@(posedge i_clk);
		i_read <= 1'b0;
		#1 check("read data", o_rdata, exp);
	endtask : rd

	// Cycles between two events: 0 cpu edge, 1 cycle end, 2 peripheral
	task automatic gap(input int k, output int c);
		c = 0;
		do @(posedge i_clk); while (!(k == 0 ? o_cpu_src_tick :
			k == 1 ? o_cpu_cycle_tick : o_periph_tick));
		do begin @(posedge i_clk); c++; end
		while (!(k == 0 ? o_cpu_src_tick :
			k == 1 ? o_cpu_cycle_tick : o_periph_tick));
	endtask : gap

	// Bounded wait for the active source
	task automatic wait_on(input logic v);
		repeat (200) if (o_cpu_on_fast !== v) @(posedge i_clk);
		check("cpu source", o_cpu_on_fast, v);
	endtask : wait_on

	// Counts, verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// Watchdog against a hang
	initial
	begin
		repeat (90000) @(posedge i_clk);
		miscompares++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		repeat (8) @(posedge i_clk);
		i_reset <= 1'b0;
		rd(CLK_CTRL_ADDR, 4'h0);
		rd(PRESCALE_ADDR, 4'h3);
		rd(16'hFF04, 4'h0);
		gap(0, n);
		check("slow edge gap", n, SP);
		gap(1, n);
		check("slow cycle", n, 2 * SP);
		$display("test defaults done");
		wr(CLK_CTRL_ADDR, 4'hC);
		rd(CLK_CTRL_ADDR, 4'h4);
		wait_on(1'b0);
		$display("test refused select done");
		wr(CLK_CTRL_ADDR, 4'h1);
		wr(CLK_CTRL_ADDR, 4'h5);
		wr(CLK_CTRL_ADDR, 4'hD);
		rd(CLK_CTRL_ADDR, 4'hD);
		wait_on(1'b1);
		gap(0, n);
		check("fast edge gap", n, FP);
		gap(1, n);
		check("fast cycle", n, 2 * FP);
		wr(CLK_CTRL_ADDR, 4'h5);
		wait_on(1'b0);
		wr(CLK_CTRL_ADDR, 4'h1);
		wr(CLK_CTRL_ADDR, 4'h0);
		rd(CLK_CTRL_ADDR, 4'h0);
		gap(0, n);
		check("slow again", n, SP);
		$display("test switching done");
		for (int c = 3; c >= 0; c--)
		begin
			if (c != 3)
				wr(PRESCALE_ADDR, 4'(c));
			rd(PRESCALE_ADDR, 4'(c));
			gap(2, n);
			check("tick", n, SP * (c > 1 ? 600 : c == 1 ? 300 : 128));
		end
		$display("test prescaler done");
		report_and_stop();
	end
endmodule : ccsw_clock_switch_tb

bind ccsw_clock_switch ccsw_checker #(
	.SLOW_DIV_P(SLOW_DIV_P), .FAST_DIV_P(FAST_DIV_P)) ccsw_checker_i (
	.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
	.o_slow_tick(o_slow_tick), .o_fast_tick(o_fast_tick),
	.o_fast_osc_running(o_fast_osc_running),
	.o_core_voltage_high(o_core_voltage_high),
	.o_cpu_src_tick(o_cpu_src_tick), .o_cpu_cycle_tick(o_cpu_cycle_tick),
	.o_cpu_on_fast(o_cpu_on_fast), .o_periph_tick(o_periph_tick));
`default_nettype wire
